// *** core/ocr_pkg.sv ***
// Shared constants, register map and types for the output clock routing block.
package ocr_pkg;
   localparam int DIV_W = 7;
   localparam int NUM_MAIN = 4;
   localparam int NUM_LOOPS = 3;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 7;
   localparam int MEM_DEPTH = 88;
   localparam int SYNC_STAGES = 2;

   // Byte addresses of the configuration map.
   localparam logic [ADDR_W-1:0] ADDR_DIV_A0 = 7'h08;
   localparam logic [ADDR_W-1:0] ADDR_DIV_A1 = 7'h09;
   localparam logic [ADDR_W-1:0] ADDR_DIV_B0 = 7'h0A;
   localparam logic [ADDR_W-1:0] ADDR_DIV_B1 = 7'h0B;
   localparam logic [ADDR_W-1:0] ADDR_DIV_C = 7'h0C;
   localparam logic [ADDR_W-1:0] ADDR_DIV_D = 7'h0D;
   localparam logic [ADDR_W-1:0] ADDR_SRC_HI = 7'h0E;
   localparam logic [ADDR_W-1:0] ADDR_OUT_CTRL = 7'h0F;
   localparam logic [ADDR_W-1:0] ADDR_DRIVE = 7'h10;
   localparam logic [ADDR_W-1:0] ADDR_LOOP2_FIRST = 7'h11;
   localparam logic [ADDR_W-1:0] ADDR_LOOP2_CTRL = 7'h13;
   localparam logic [ADDR_W-1:0] ADDR_LOOP3_CTRL = 7'h16;
   localparam logic [ADDR_W-1:0] ADDR_OSC = 7'h17;
   localparam logic [ADDR_W-1:0] ADDR_SUSP_OUT = 7'h18;
   localparam logic [ADDR_W-1:0] ADDR_SUSP_LOOP = 7'h19;
   localparam logic [ADDR_W-1:0] ADDR_TABLE_BASE = 7'h40;
   localparam logic [ADDR_W-1:0] ADDR_TABLE_LAST = 7'h57;
   localparam logic [ADDR_W-1:0] TABLE_STRIDE = 7'h03;
   localparam logic [ADDR_W-1:0] TABLE_CTRL_OFS = 7'h02;

   localparam logic [NUM_MAIN-1:0][ADDR_W-1:0] DIV_ADDR_BANK0 = {ADDR_DIV_D, ADDR_DIV_C, ADDR_DIV_B0, ADDR_DIV_A0};
   localparam logic [NUM_MAIN-1:0][ADDR_W-1:0] DIV_ADDR_BANK1 = {ADDR_DIV_D, ADDR_DIV_C, ADDR_DIV_B1, ADDR_DIV_A1};

   // Field positions.
   localparam int BIT_FS0 = 7;
   localparam int BIT_PIN_FUNC = 3;
   localparam int BIT_REF_BUF_EN = 2;
   localparam int BIT_E_DIV_LO = 0;
   localparam int BIT_LOOP_EN = 6;
   localparam int BIT_BANK_SEL = 7;
   localparam int BIT_SUSP_MODE = 7;
   localparam int BIT_OSC_CAP_LO = 2;
   localparam int OSC_CAP_W = 6;
   localparam int NUM_OUTS = 5;

   localparam logic [BYTE_W-1:0] RESET_BYTE = 8'h00;
   localparam logic [DIV_W-1:0] DIV_OFF = 7'h00;

   // Fifth output divider codes and the ratios they stand for.
   localparam logic [1:0] E_CODE_OFF = 2'h0;
   localparam logic [1:0] E_CODE_DIV4 = 2'h1;
   localparam logic [1:0] E_CODE_DIV2 = 2'h2;
   localparam logic [1:0] E_CODE_DIV3 = 2'h3;
   localparam logic [DIV_W-1:0] E_RATIO_4 = 7'h04;
   localparam logic [DIV_W-1:0] E_RATIO_2 = 7'h02;
   localparam logic [DIV_W-1:0] E_RATIO_3 = 7'h03;

   // Main output source codes.
   localparam logic [2:0] SRC_REF = 3'h0;
   localparam logic [2:0] SRC_RSVD = 3'h1;
   localparam logic [2:0] SRC_L1_P0 = 3'h2;
   localparam logic [2:0] SRC_L1_P180 = 3'h3;
   localparam logic [2:0] SRC_L2_P0 = 3'h4;
   localparam logic [2:0] SRC_L2_P180 = 3'h5;
   localparam logic [2:0] SRC_L3_P0 = 3'h6;
   localparam logic [2:0] SRC_L3_P180 = 3'h7;

   typedef enum logic [1:0] {
      OCR_ST_WAIT = 2'h0,
      OCR_ST_FILL = 2'h1,
      OCR_ST_LATCH = 2'h3,
      OCR_ST_RUN = 2'h2
   } ocr_state_t;

   typedef struct packed {
      logic [2:0] src_code;
      logic [DIV_W-1:0] ratio0;
      logic [DIV_W-1:0] ratio1;
   } ocr_main_cfg_t;
endpackage : ocr_pkg

// *** core/ocr_sync.sv ***
// Two-stage synchroniser for asynchronous pin inputs.
`timescale 1ns/1ps
module ocr_sync #(
   parameter int WIDTH = 1,
   parameter int STAGES = ocr_pkg::SYNC_STAGES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [STAGES-1:0][WIDTH-1:0] stage_r;

   if (STAGES < 2) begin : g_bad_stages
      $error("ocr_sync needs at least two stages");
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stage_r <= '0;
      end else begin
         stage_r <= {stage_r[STAGES-2:0], async_in};
      end
   end

   assign sync_out = stage_r[STAGES-1];
endmodule : ocr_sync

// *** core/ocr_post_div.sv ***
// Post divider counting source half periods, with a bank switch applied only at a safe edge.
`timescale 1ns/1ps
module ocr_post_div #(
   parameter int WIDTH = ocr_pkg::DIV_W
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic run,
   input wire logic src,
   input wire logic [WIDTH-1:0] ratio0,
   input wire logic [WIDTH-1:0] ratio1,
   input wire logic bank_sel,
   output logic clk_out
);
   logic src_d_r;
   logic bank_r;
   logic [WIDTH-1:0] cnt_r;
   logic out_r;
   logic [WIDTH-1:0] ratio;
   logic src_edge;
   logic wrap;

   if (WIDTH < 2) begin : g_bad_width
      $error("ocr_post_div width too small");
   end

   assign ratio = bank_r ? ratio1 : ratio0;
   assign src_edge = src ^ src_d_r;
   assign wrap = src_edge && ({1'b0, cnt_r} + {{WIDTH{1'b0}}, 1'b1} >= {1'b0, ratio});

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         src_d_r <= 1'b0;
      end else begin
         src_d_r <= src;
      end
   end

   // Toggling every ratio half periods gives fifty percent duty for odd ratios too.
   always_ff @(posedge clock) begin
      if (!rst_n || !run || ratio == '0) begin
         cnt_r <= '0;
         out_r <= 1'b0;
      end else if (wrap) begin
         cnt_r <= '0;
         out_r <= ~out_r;
      end else if (src_edge) begin
         cnt_r <= WIDTH'(cnt_r + 1'b1);
      end
   end

   // A bank change waits until the output falls or is already low, so no short pulse appears.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bank_r <= 1'b0;
      end else if (!out_r && !src_edge) begin
         bank_r <= bank_sel;
      end else if (wrap && out_r) begin
         bank_r <= bank_sel;
      end
   end

   assign clk_out = out_r;
endmodule : ocr_post_div

// *** core/ocr_top.sv ***
// Output clock routing, post dividers, shutdown and suspend control.
//
// Behaviour
// - Cross point routes reference or any loop into each of four 7-bit dividers.
// - Outputs A and B pick one of two divider registers by the bank select bit.
// - Outputs C and D use one divider register each, never switched.
// - Output E divides loop one: 00 off, 01 by four, 10 by two, 11 by three.
// - Main dividers take ratios 1 to 127; zero powers down and tristates.
// - Odd ratios get fifty percent duty without extra setup.
// - Three-bit source code picks reference or a loop at 0 or 180 degrees.
// - Reference buffer drives only while its enable bit is high.
// - Pin-function bit high makes the pin full shutdown, low makes it output enable.
// - Shutdown pin low tristates every clock output.
// - Full shutdown also stops loops, counters and the oscillator.
// - Suspend low stops chosen loops fully and tristates chosen outputs.
// - Each loop and output can be disabled on its own by configuration.
// - Divider writes act immediately and may glitch an active output.
// - Each configuration byte takes effect at its own acknowledge.
// - Configuration writes keep working while the shutdown pin is low.
// - Crystal load setting may be rewritten at run time.
// - Serial pin levels latched at start-up plus live third select index the table.
// - Bank changes from the third select input are glitch free.
// - Loop one disabled turns off every output derived from it.
`timescale 1ns/1ps
module ocr_top (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [ocr_pkg::ADDR_W-1:0] cfg_addr,
   input wire logic [ocr_pkg::BYTE_W-1:0] cfg_wdata,
   input wire logic cfg_we,
   input wire logic cfg_re,
   output logic [ocr_pkg::BYTE_W-1:0] cfg_rdata,
   output logic cfg_rvalid,
   input wire logic select_bit_zero_pin,
   input wire logic select_bit_one_pin,
   input wire logic third_select_or_suspend_pin,
   input wire logic shutdown_oe_pin,
   input wire logic ref_src,
   input wire logic [ocr_pkg::NUM_LOOPS-1:0] loop_src,
   output logic output_clock_a,
   output logic output_clock_b,
   output logic output_clock_c,
   output logic output_clock_d,
   output logic output_clock_e,
   output logic [ocr_pkg::NUM_OUTS-1:0] output_oe,
   output logic ref_buffer_out,
   output logic ref_buffer_oe,
   output logic [ocr_pkg::NUM_LOOPS-1:0] loop_run,
   output logic osc_run,
   output logic [ocr_pkg::OSC_CAP_W-1:0] osc_cap
);
   logic [ocr_pkg::BYTE_W-1:0] cfg_mem [ocr_pkg::MEM_DEPTH];
   logic [3:0] pins_s;
   logic sel0_s;
   logic sel1_s;
   logic sel2_s;
   logic sd_pin_s;
   ocr_pkg::ocr_state_t state_r;
   logic [2:0] idx_lat_r;
   logic [2:0] idx;
   logic [ocr_pkg::ADDR_W-1:0] entry_addr;
   logic [ocr_pkg::BYTE_W-1:0] entry;
   logic susp_mode;
   logic susp_active;
   logic outputs_off;
   logic full_shutdown;
   logic [ocr_pkg::NUM_LOOPS-1:0] loop_cfg_en;
   logic [ocr_pkg::NUM_LOOPS-1:0] loop_ok;
   logic [ocr_pkg::NUM_OUTS-1:0] susp_out;
   logic [ocr_pkg::NUM_OUTS-1:0] div_out;
   logic [ocr_pkg::NUM_OUTS-1:0] oe_nxt;
   logic [1:0] e_code;
   logic [ocr_pkg::DIV_W-1:0] e_ratio;
   logic bank_sel;

   function automatic logic is_mapped(input logic [ocr_pkg::ADDR_W-1:0] a);
      return (a >= ocr_pkg::ADDR_DIV_A0 && a <= ocr_pkg::ADDR_SUSP_LOOP) ||
             (a >= ocr_pkg::ADDR_TABLE_BASE && a <= ocr_pkg::ADDR_TABLE_LAST);
   endfunction : is_mapped

   // Returns 1 to 3 for the loop feeding a source code, 0 for the reference.
   function automatic logic [1:0] src_loop(input logic [2:0] code);
      case (code)
         ocr_pkg::SRC_L1_P0, ocr_pkg::SRC_L1_P180: begin
            return 2'h1;
         end
         ocr_pkg::SRC_L2_P0, ocr_pkg::SRC_L2_P180: begin
            return 2'h2;
         end
         ocr_pkg::SRC_L3_P0, ocr_pkg::SRC_L3_P180: begin
            return 2'h3;
         end
         default: begin
            return 2'h0;
         end
      endcase
   endfunction : src_loop

   function automatic logic pick_src(input logic [2:0] code, input logic r, input logic [2:0] l);
      case (code)
         ocr_pkg::SRC_REF: begin
            return r;
         end
         ocr_pkg::SRC_L1_P0: begin
            return l[0];
         end
         ocr_pkg::SRC_L1_P180: begin
            return ~l[0];
         end
         ocr_pkg::SRC_L2_P0: begin
            return l[1];
         end
         ocr_pkg::SRC_L2_P180: begin
            return ~l[1];
         end
         ocr_pkg::SRC_L3_P0: begin
            return l[2];
         end
         ocr_pkg::SRC_L3_P180: begin
            return ~l[2];
         end
         default: begin
            return 1'b0;
         end
      endcase
   endfunction : pick_src

   ocr_sync #(.WIDTH(4), .STAGES(ocr_pkg::SYNC_STAGES)) u_pin_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in({shutdown_oe_pin, third_select_or_suspend_pin, select_bit_one_pin, select_bit_zero_pin}),
      .sync_out(pins_s)
   );
   assign {sd_pin_s, sel2_s, sel1_s, sel0_s} = pins_s;

   // Each byte lands at its own strobe, also during shutdown.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         for (int i = 0; i < ocr_pkg::MEM_DEPTH; i++) begin
            cfg_mem[i] <= ocr_pkg::RESET_BYTE;
         end
      end else if (cfg_we && is_mapped(cfg_addr)) begin
         cfg_mem[cfg_addr] <= cfg_wdata;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cfg_rdata <= ocr_pkg::RESET_BYTE;
         cfg_rvalid <= 1'b0;
      end else begin
         cfg_rvalid <= cfg_re;
         if (cfg_re) begin
            cfg_rdata <= is_mapped(cfg_addr) ? cfg_mem[cfg_addr] : ocr_pkg::RESET_BYTE;
         end
      end
   end

   // Start-up: wait for the synchroniser to fill, then latch the serial pin levels once.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_r <= ocr_pkg::OCR_ST_WAIT;
         idx_lat_r <= 3'h0;
      end else begin
         case (state_r)
            ocr_pkg::OCR_ST_WAIT: begin
               state_r <= ocr_pkg::OCR_ST_FILL;
            end
            ocr_pkg::OCR_ST_FILL: begin
               state_r <= ocr_pkg::OCR_ST_LATCH;
            end
            ocr_pkg::OCR_ST_LATCH: begin
               idx_lat_r <= {1'b0, sel1_s, sel0_s};
               state_r <= ocr_pkg::OCR_ST_RUN;
            end
            ocr_pkg::OCR_ST_RUN: begin
               state_r <= ocr_pkg::OCR_ST_RUN;
            end
            default: begin
               state_r <= ocr_pkg::OCR_ST_WAIT;
            end
         endcase
      end
   end

   assign susp_mode = cfg_mem[ocr_pkg::ADDR_SUSP_LOOP][ocr_pkg::BIT_SUSP_MODE];
   assign susp_active = susp_mode && !sel2_s;
   assign idx = {(susp_mode ? 1'b0 : sel2_s), idx_lat_r[1:0]};
   assign entry_addr = ocr_pkg::ADDR_TABLE_BASE + ocr_pkg::ADDR_W'(idx * ocr_pkg::TABLE_STRIDE) +
                       ocr_pkg::TABLE_CTRL_OFS;
   assign entry = cfg_mem[entry_addr];
   assign bank_sel = entry[ocr_pkg::BIT_BANK_SEL];

   assign outputs_off = !sd_pin_s;
   assign full_shutdown = cfg_mem[ocr_pkg::ADDR_OUT_CTRL][ocr_pkg::BIT_PIN_FUNC] && !sd_pin_s;
   assign loop_cfg_en = {cfg_mem[ocr_pkg::ADDR_LOOP3_CTRL][ocr_pkg::BIT_LOOP_EN],
                         cfg_mem[ocr_pkg::ADDR_LOOP2_CTRL][ocr_pkg::BIT_LOOP_EN],
                         entry[ocr_pkg::BIT_LOOP_EN]};
   assign loop_ok = loop_cfg_en &
                    ~(cfg_mem[ocr_pkg::ADDR_SUSP_LOOP][ocr_pkg::NUM_LOOPS-1:0] & {ocr_pkg::NUM_LOOPS{susp_active}}) &
                    {ocr_pkg::NUM_LOOPS{!full_shutdown}};
   assign susp_out = cfg_mem[ocr_pkg::ADDR_SUSP_OUT][ocr_pkg::NUM_OUTS-1:0] &
                     {ocr_pkg::NUM_OUTS{susp_active}};

   genvar k;
   generate
      for (k = 0; k < ocr_pkg::NUM_MAIN; k++) begin : g_main
         ocr_pkg::ocr_main_cfg_t mcfg;
         logic [1:0] lp;
         logic src_ok;
         assign mcfg.src_code = {cfg_mem[ocr_pkg::ADDR_SRC_HI][2*k+1 -: 2],
                                 cfg_mem[ocr_pkg::DIV_ADDR_BANK0[k]][ocr_pkg::BIT_FS0]};
         assign mcfg.ratio0 = cfg_mem[ocr_pkg::DIV_ADDR_BANK0[k]][ocr_pkg::DIV_W-1:0];
         assign mcfg.ratio1 = cfg_mem[ocr_pkg::DIV_ADDR_BANK1[k]][ocr_pkg::DIV_W-1:0];
         assign lp = src_loop(mcfg.src_code);
         assign src_ok = (lp == 2'h0) ? !full_shutdown : loop_ok[lp - 2'h1];
         ocr_post_div #(.WIDTH(ocr_pkg::DIV_W)) u_div (
            .clock(clock),
            .rst_n(rst_n),
            .run(src_ok),
            .src(pick_src(mcfg.src_code, ref_src, loop_src)),
            .ratio0(mcfg.ratio0),
            .ratio1(mcfg.ratio1),
            .bank_sel((k < 2) ? bank_sel : 1'b0),
            .clk_out(div_out[k])
         );
         assign oe_nxt[k] = (mcfg.ratio0 != ocr_pkg::DIV_OFF || (k < 2 && mcfg.ratio1 != ocr_pkg::DIV_OFF)) &&
                            ((k < 2 && bank_sel) ? mcfg.ratio1 : mcfg.ratio0) != ocr_pkg::DIV_OFF &&
                            src_ok && !outputs_off && !susp_out[k];
      end
   endgenerate

   assign e_code = cfg_mem[ocr_pkg::ADDR_OUT_CTRL][ocr_pkg::BIT_E_DIV_LO +: 2];
   always_comb begin
      case (e_code)
         ocr_pkg::E_CODE_DIV4: begin
            e_ratio = ocr_pkg::E_RATIO_4;
         end
         ocr_pkg::E_CODE_DIV2: begin
            e_ratio = ocr_pkg::E_RATIO_2;
         end
         ocr_pkg::E_CODE_DIV3: begin
            e_ratio = ocr_pkg::E_RATIO_3;
         end
         default: begin
            e_ratio = ocr_pkg::DIV_OFF;
         end
      endcase
   end

   ocr_post_div #(.WIDTH(ocr_pkg::DIV_W)) u_div_e (
      .clock(clock),
      .rst_n(rst_n),
      .run(loop_ok[0]),
      .src(loop_src[0]),
      .ratio0(e_ratio),
      .ratio1(e_ratio),
      .bank_sel(1'b0),
      .clk_out(div_out[ocr_pkg::NUM_OUTS-1])
   );
   assign oe_nxt[ocr_pkg::NUM_OUTS-1] = e_code != ocr_pkg::E_CODE_OFF && loop_ok[0] && !outputs_off &&
                                        !susp_out[ocr_pkg::NUM_OUTS-1];

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         {output_clock_e, output_clock_d, output_clock_c, output_clock_b, output_clock_a} <= '0;
         output_oe <= '0;
      end else begin
         {output_clock_e, output_clock_d, output_clock_c, output_clock_b, output_clock_a} <= div_out & oe_nxt;
         output_oe <= oe_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ref_buffer_out <= 1'b0;
         ref_buffer_oe <= 1'b0;
      end else begin
         ref_buffer_oe <= cfg_mem[ocr_pkg::ADDR_OUT_CTRL][ocr_pkg::BIT_REF_BUF_EN] && !outputs_off;
         ref_buffer_out <= ref_src && cfg_mem[ocr_pkg::ADDR_OUT_CTRL][ocr_pkg::BIT_REF_BUF_EN] && !outputs_off;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         loop_run <= '0;
         osc_run <= 1'b0;
         osc_cap <= '0;
      end else begin
         loop_run <= loop_ok;
         osc_run <= !full_shutdown;
         osc_cap <= cfg_mem[ocr_pkg::ADDR_OSC][ocr_pkg::BIT_OSC_CAP_LO +: ocr_pkg::OSC_CAP_W];
      end
   end
endmodule : ocr_top

// *** sim/ocr_chk.sv ***
// Assertion checker for the output clock routing block.
`timescale 1ns/1ps
module ocr_chk (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [ocr_pkg::ADDR_W-1:0] cfg_addr,
   input wire logic [ocr_pkg::BYTE_W-1:0] cfg_wdata,
   input wire logic cfg_we,
   input wire logic cfg_re,
   input wire logic cfg_rvalid,
   input wire logic shutdown_oe_pin,
   input wire logic ref_src,
   input wire logic output_clock_a,
   input wire logic output_clock_b,
   input wire logic output_clock_c,
   input wire logic output_clock_d,
   input wire logic output_clock_e,
   input wire logic [ocr_pkg::NUM_OUTS-1:0] output_oe,
   input wire logic ref_buffer_out,
   input wire logic ref_buffer_oe,
   input wire logic [ocr_pkg::OSC_CAP_W-1:0] osc_cap
);
   logic [ocr_pkg::OSC_CAP_W-1:0] cap_exp_r;
   wire cap_wr = cfg_we && cfg_addr == ocr_pkg::ADDR_OSC;
   always_ff @(posedge clock) begin
      if (cap_wr) begin
         cap_exp_r <= cfg_wdata[7:2];
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_read_answer; cfg_re |=> cfg_rvalid; endproperty
   a_read_answer: assert property (p_read_answer) else $error("read not answered");
   property p_rvalid_cause; cfg_rvalid |-> $past(cfg_re); endproperty
   a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray read valid");
   property p_oe_gates;
      ({output_clock_e, output_clock_d, output_clock_c, output_clock_b, output_clock_a} & ~output_oe) == 5'h00;
   endproperty
   a_oe_gates: assert property (p_oe_gates) else $error("clock active while disabled");
   property p_pin_low; !shutdown_oe_pin [*4] |-> output_oe == 5'h00 && !ref_buffer_oe; endproperty
   a_pin_low: assert property (p_pin_low) else $error("outputs driven with pin low");
   property p_buf_gate; !ref_buffer_oe |-> !ref_buffer_out; endproperty
   a_buf_gate: assert property (p_buf_gate) else $error("buffer active while off");
   property p_buf_copy; ref_buffer_oe && $past(ref_buffer_oe) |-> ref_buffer_out == $past(ref_src); endproperty
   a_buf_copy: assert property (p_buf_copy) else $error("buffer not following reference");
   property p_osc_cap; cap_wr ##1 !cap_wr |=> osc_cap == cap_exp_r; endproperty
   a_osc_cap: assert property (p_osc_cap) else $error("load code not applied");
   property p_div_zero;
      cfg_we && cfg_addr == ocr_pkg::ADDR_DIV_C && cfg_wdata[6:0] == ocr_pkg::DIV_OFF
      ##1 !(cfg_we && cfg_addr == ocr_pkg::ADDR_DIV_C) |=> !output_oe[2];
   endproperty
   a_div_zero: assert property (p_div_zero) else $error("zero ratio left output on");
   property p_e_off;
      cfg_we && cfg_addr == ocr_pkg::ADDR_OUT_CTRL && cfg_wdata[1:0] == ocr_pkg::E_CODE_OFF
      ##1 !(cfg_we && cfg_addr == ocr_pkg::ADDR_OUT_CTRL) |=> !output_oe[4];
   endproperty
   a_e_off: assert property (p_e_off) else $error("fifth output not off");
endmodule : ocr_chk
bind ocr_top ocr_chk chk_u (.*);

// *** sim/ocr_host.sv ***
// Serial programming host model driving the configuration byte port.
`timescale 1ns/1ps
module ocr_host (
   input wire logic clock,
   output logic [ocr_pkg::ADDR_W-1:0] cfg_addr,
   output logic [ocr_pkg::BYTE_W-1:0] cfg_wdata,
   output logic cfg_we,
   output logic cfg_re,
   input wire logic [ocr_pkg::BYTE_W-1:0] cfg_rdata,
   input wire logic cfg_rvalid
);
   initial begin
      cfg_addr = 7'h00;
      cfg_wdata = 8'h00;
      cfg_we = 1'b0;
      cfg_re = 1'b0;
   end
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      cfg_addr = a;
      cfg_wdata = d;
      cfg_we = 1'b1;
      @(posedge clock);
      #1;
      cfg_we = 1'b0;
      cfg_addr = ~a;
      cfg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      int n;
      @(posedge clock);
      #1;
      cfg_addr = a;
      cfg_re = 1'b1;
      @(posedge clock);
      #1;
      cfg_re = 1'b0;
      cfg_addr = ~a;
      n = 0;
      while (cfg_rvalid !== 1'b1 && n < 4) begin
         @(posedge clock);
         #1;
         n++;
      end
      d = cfg_rdata;
   endtask : rd
endmodule : ocr_host

// *** sim/test_output_clock_routing_and_dividers.sv ***
// Testbench for the output clock routing block.
`timescale 1ns/1ps
module test_output_clock_routing_and_dividers;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [6:0] cfg_addr;
   logic [7:0] cfg_wdata, cfg_rdata, rv;
   logic cfg_we, cfg_re, cfg_rvalid;
   logic select_bit_zero_pin = 1'b0;
   logic select_bit_one_pin = 1'b1;
   logic third_select_or_suspend_pin = 1'b0;
   logic shutdown_oe_pin = 1'b1;
   logic ref_src = 1'b0;
   logic [2:0] loop_src = 3'h0;
   logic output_clock_a, output_clock_b, output_clock_c, output_clock_d, output_clock_e;
   logic [4:0] output_oe;
   logic ref_buffer_out, ref_buffer_oe, osc_run;
   logic [2:0] loop_run;
   logic [5:0] osc_cap;
   int mismatches = 0;
   int cmp_count = 0;
   int tk = 0;
   int hs[4] = '{1, 2, 3, 4};
   int eh[4] = '{0, 4, 2, 3};
   wire [4:0] outs = {output_clock_e, output_clock_d, output_clock_c, output_clock_b, output_clock_a};
   ocr_top dut_u (.*);
   ocr_host host_u (.*);
   always #4 clock = ~clock;
   // Sources change every 1, 2, 3 and 4 cycles.
   always @(posedge clock) begin
      #1;
      tk = tk + 1;
      ref_src = ~ref_src;
      for (int k = 0; k < 3; k++) begin
         if (tk % (k + 2) == 0) begin
            loop_src[k] = ~loop_src[k];
         end
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got %0h expected %0h", $time, got, exp);
      end
   endtask : chk
   task automatic wl(input int i, input logic v);
      int n;
      n = 0;
      while (outs[i] !== v && n < 600) begin
         @(posedge clock);
         #1;
         n++;
      end
   endtask : wl
   task automatic meas(input int i, input int h);
      int n;
      repeat (2) begin
         wl(i, 1'b0);
         wl(i, 1'b1);
      end
      for (int p = 0; p < 2; p++) begin
         n = 0;
         while (outs[i] === !p[0] && n < 600) begin
            @(posedge clock);
            #1;
            n++;
         end
         chk(n, h);
      end
   endtask : meas
   task automatic pause(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : pause
   task automatic finish_test;
      $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   initial begin
      #600000;
      mismatches++;
      finish_test();
   end
   initial begin
      repeat (10) @(posedge clock);
      #1;
      rst_n = 1'b1;
      pause(3);
      select_bit_one_pin = 1'b0;
      host_u.rd(7'h0F, rv);
      chk(rv, 8'h00);
      host_u.wr(7'h20, 8'hA5);
      host_u.rd(7'h20, rv);
      chk(rv, 8'h00);
      host_u.wr(7'h48, 8'h40);
      host_u.wr(7'h54, 8'hC0);
      host_u.wr(7'h13, 8'h40);
      host_u.wr(7'h16, 8'h40);
      for (int c = 0; c < 8; c++) begin
         if (c != 1) begin
            host_u.wr(7'h0E, 8'(c >> 1) << 4);
            host_u.wr(7'h0C, {c[0], 7'h02});
            meas(2, 2 * hs[c >> 1]);
         end
      end
      host_u.wr(7'h0E, 8'h00);
      for (int r = 1; r < 128; r = r * 3 + (r == 9 ? 100 : 0)) begin
         host_u.wr(7'h0C, 8'(r));
         meas(2, r);
      end
      host_u.wr(7'h0C, 8'h00);
      pause(3);
      chk(output_oe[2], 1'b0);
      host_u.wr(7'h08, 8'h02);
      host_u.wr(7'h09, 8'h05);
      host_u.wr(7'h0A, 8'h03);
      host_u.wr(7'h0B, 8'h04);
      host_u.wr(7'h0C, 8'h03);
      host_u.wr(7'h0D, 8'h04);
      meas(0, 2);
      meas(1, 3);
      third_select_or_suspend_pin = 1'b1;
      meas(0, 5);
      meas(1, 4);
      meas(2, 3);
      meas(3, 4);
      third_select_or_suspend_pin = 1'b0;
      for (int e = 1; e < 4; e++) begin
         host_u.wr(7'h0F, 8'(e));
         meas(4, 2 * eh[e]);
      end
      host_u.wr(7'h0F, 8'h04);
      pause(3);
      chk(ref_buffer_oe, 1'b1);
      host_u.wr(7'h0F, 8'h00);
      pause(3);
      chk(ref_buffer_oe, 1'b0);
      shutdown_oe_pin = 1'b0;
      pause(5);
      chk(output_oe, 5'h00);
      chk(osc_run, 1'b1);
      host_u.wr(7'h0D, 8'h5A);
      host_u.rd(7'h0D, rv);
      chk(rv, 8'h5A);
      shutdown_oe_pin = 1'b1;
      pause(5);
      chk(output_oe[0], 1'b1);
      host_u.wr(7'h0F, 8'h08);
      shutdown_oe_pin = 1'b0;
      pause(5);
      chk(osc_run, 1'b0);
      chk(loop_run, 3'h0);
      shutdown_oe_pin = 1'b1;
      pause(5);
      chk(osc_run, 1'b1);
      host_u.wr(7'h0F, 8'h00);
      host_u.wr(7'h0E, 8'h30);
      host_u.wr(7'h18, 8'h04);
      host_u.wr(7'h19, 8'h84);
      pause(5);
      chk(loop_run, 3'h3);
      chk(output_oe[2:0], 3'h3);
      host_u.wr(7'h19, 8'h00);
      host_u.wr(7'h13, 8'h00);
      pause(3);
      chk(loop_run, 3'h5);
      host_u.wr(7'h0E, 8'h01);
      meas(0, 4);
      host_u.wr(7'h48, 8'h00);
      pause(3);
      chk(output_oe[0], 1'b0);
      host_u.wr(7'h17, 8'hFC);
      pause(3);
      chk(osc_cap, 6'h3F);
      finish_test();
   end
endmodule : test_output_clock_routing_and_dividers
